// ### ufs_pkg.sv
/*
  Package for the queue status flag block: register map, field positions,
  reset values and the bus carrier struct.
  Assumes a classic Wishbone master with 32-bit data and byte addresses.
*/
package ufs_pkg;
  // ***********************************************************
  // Register offsets (byte addresses)
  // ***********************************************************
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_TX_DATA = 8'h04;
  localparam logic [7:0] OFF_RX_DATA = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0c;
  localparam logic [7:0] OFF_THRESH = 8'h10;
  localparam logic [7:0] OFF_LEVELS = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
  // ***********************************************************
  // Field positions
  // ***********************************************************
  localparam int BIT_RX_WAIT = 0;
  localparam int BIT_RX_FULL = 1;
  localparam int BIT_TX_SPACE = 2;
  localparam int BIT_OVERRUN = 3;
  localparam int BIT_TX_EN = 0;
  localparam int BIT_RX_EN = 1;
  localparam int NUM_IRQ = 4;
  // ***********************************************************
  // Sizes and reset values
  // ***********************************************************
  localparam int DEPTH = 256;
  localparam int AW = 8;
  localparam logic [8:0] DEPTH_CNT = 9'h100;
  localparam logic [8:0] THRESH_RST = 9'h100;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [NUM_IRQ-1:0] IRQ_RST = 4'h0;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } ufs_wb_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ufs_char_t;
endpackage

// ### ufs_queue_flags.sv
/*
  Queue status flag logic of one serial channel, with both 256-entry
  queues, the receive holding stage, and a Wishbone slave.
  Holds: bus decode, transmit queue, receive queue with one holding
  stage, the three status flags, control, threshold and interrupts.
  Assumes the serial shifters outside: the transmit shifter pops
  characters, the receive shifter pushes characters and start events.
  Assumes a classic Wishbone master that holds each request until ack
  and drops it for at least one cycle afterwards.
  Assumes every input is synchronous to ref_clk_i; no synchroniser
  is placed on the shifter strobes.
  Assumes rst_i is held for at least one rising edge.
*/
// Overview of operation
// - Transmit-space flag (status bit 2) is high while the transmit queue is not full and its level is at or below the threshold.
// - Transmit-space flag is low when the queue is full or its level is above the threshold.
// - Characters written while the transmitter is disabled stay queued and go to the shifter once it is enabled.
// - Receive-full flag (status bit 1) sets when a transfer fills all 256 positions.
// - Receive-full flag clears when a host read leaves at least one empty position.
// - A char held in the holding stage loads on a host read, so full clears on the second read.
// - Character-waiting flag (status bit 0) sets when a received char enters the queue.
// - Character-waiting flag clears when a host read leaves the queue empty.
// - A start bit while full with a char already held discards the held char (257 max).
`timescale 1ns/1ns
module ufs_queue_flags (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire ufs_pkg::ufs_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire ufs_pkg::ufs_char_t rx_char_i,
  input wire logic rx_start_i,
  input wire logic tx_pop_i,
  output ufs_pkg::ufs_char_t tx_char_o,
  output logic irq_o
);
  import ufs_pkg::*;

  // ***********************************************************
  // Bus decode
  // ***********************************************************
  logic access;
  logic wr_en;
  logic rd_en;
  logic lane0;
  assign access = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  assign wr_en = access & wb_req_i.we;
  assign rd_en = access & ~wb_req_i.we;
  assign lane0 = wb_req_i.sel[0];

  // One-hot register selects; an unmapped address selects nothing
  logic hit_status;
  logic hit_tx_data;
  logic hit_rx_data;
  logic hit_ctrl;
  logic hit_thresh;
  logic hit_levels;
  logic hit_irq_stat;
  logic hit_irq_mask;
  assign hit_status = (wb_req_i.adr == OFF_STATUS);
  assign hit_tx_data = (wb_req_i.adr == OFF_TX_DATA);
  assign hit_rx_data = (wb_req_i.adr == OFF_RX_DATA);
  assign hit_ctrl = (wb_req_i.adr == OFF_CTRL);
  assign hit_thresh = (wb_req_i.adr == OFF_THRESH);
  assign hit_levels = (wb_req_i.adr == OFF_LEVELS);
  assign hit_irq_stat = (wb_req_i.adr == OFF_IRQ_STAT);
  assign hit_irq_mask = (wb_req_i.adr == OFF_IRQ_MASK);

  logic [1:0] ctrl_r;
  logic [8:0] thresh_r;
  logic [NUM_IRQ-1:0] irq_stat_r;
  logic [NUM_IRQ-1:0] irq_mask_r;
  logic tx_en;
  logic rx_en;
  logic rx_accept;
  // Enables split out so every user reads the same field
  assign tx_en = ctrl_r[BIT_TX_EN];
  assign rx_en = ctrl_r[BIT_RX_EN];
  assign rx_accept = rx_char_i.valid & rx_en;

  // ***********************************************************
  // Transmit queue
  // ***********************************************************
  logic [7:0] tx_mem [DEPTH];
  logic [AW-1:0] tx_wp_r;
  logic [AW-1:0] tx_rp_r;
  logic [8:0] tx_cnt_r;
  logic tx_push;
  logic tx_pop;
  logic tx_full;
  logic tx_space;
  logic [8:0] tx_cnt_nxt;
  logic [AW-1:0] tx_head_idx;

  assign tx_full = (tx_cnt_r == DEPTH_CNT);
  assign tx_push = wr_en & lane0 & hit_tx_data & ~tx_full;
  // Disabled transmitter hides the queue from the shifter
  assign tx_pop = tx_pop_i & tx_char_o.valid;
  // Equal to the threshold still counts as space; above it, or a full queue, clears it
  assign tx_space = ~tx_full & (tx_cnt_r <= thresh_r);
  assign tx_cnt_nxt = tx_cnt_r + {8'h00, tx_push} - {8'h00, tx_pop};
  // Look one ahead on a pop so the next head stands one edge later
  assign tx_head_idx = tx_pop ? tx_rp_r + 8'h01 : tx_rp_r;

  always_ff @(posedge ref_clk_i) begin
    if (tx_push) begin
      tx_mem[tx_wp_r] <= wb_req_i.dat[7:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      tx_cnt_r <= '0;
    end else begin
      if (tx_push) begin
        tx_wp_r <= tx_wp_r + 8'h01;
      end
      if (tx_pop) begin
        tx_rp_r <= tx_rp_r + 8'h01;
      end
      tx_cnt_r <= tx_cnt_nxt;
    end
  end

  // Registered output; the look-ahead shows the next head one edge after a pop, so the shifter may pop every cycle
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_char_o <= '0;
    end else begin
      tx_char_o.valid <= tx_en & (tx_cnt_r > {8'h00, tx_pop});
      tx_char_o.data <= tx_mem[tx_head_idx];
    end
  end

  // ***********************************************************
  // Receive queue and holding stage
  // ***********************************************************
  logic [7:0] rx_mem [DEPTH];
  logic [AW-1:0] rx_wp_r;
  logic [AW-1:0] rx_rp_r;
  logic [8:0] rx_cnt_r;
  logic [7:0] hold_r;
  logic hold_vld_r;
  logic rx_full_flag_r;
  logic rx_wait_flag_r;
  logic rx_pop;
  logic rx_push;
  logic [7:0] rx_push_data;
  logic rx_full;
  logic [8:0] rx_cnt_nxt;
  logic overrun;
  logic [7:0] rx_head_r;

  assign rx_full = (rx_cnt_r == DEPTH_CNT);
  assign rx_pop = rd_en & hit_rx_data & (rx_cnt_r != 9'h000);
  // Held char goes first so arrival order is kept
  assign rx_push = (hold_vld_r | rx_char_i.valid) & rx_en & (~rx_full | rx_pop);
  assign rx_push_data = hold_vld_r ? hold_r : rx_char_i.data;
  assign rx_cnt_nxt = rx_cnt_r + {8'h00, rx_push} - {8'h00, rx_pop};
  // Overrun only when no read frees a slot in the same cycle
  assign overrun = rx_start_i & rx_full & hold_vld_r & ~rx_pop;

  always_ff @(posedge ref_clk_i) begin
    if (rx_push) begin
      rx_mem[rx_wp_r] <= rx_push_data;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      rx_cnt_r <= '0;
    end else begin
      if (rx_push) begin
        rx_wp_r <= rx_wp_r + 8'h01;
      end
      if (rx_pop) begin
        rx_rp_r <= rx_rp_r + 8'h01;
      end
      rx_cnt_r <= rx_cnt_nxt;
    end
  end

  // Head is registered, so a data read shows the entry before its pop
  always_ff @(posedge ref_clk_i) begin
    rx_head_r <= rx_mem[rx_rp_r];
  end

  // Holding stage: one char beyond the queue, 257 in all
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      hold_vld_r <= 1'b0;
      hold_r <= '0;
    end else if (overrun) begin
      hold_vld_r <= 1'b0;
    end else if (hold_vld_r) begin
      if (rx_push & ~rx_char_i.valid) begin
        hold_vld_r <= 1'b0;
      end else if (rx_push) begin
        hold_r <= rx_char_i.data;
      end
    end else if (rx_accept & ~rx_push) begin
      hold_vld_r <= 1'b1;
      hold_r <= rx_char_i.data;
    end
  end

  // Flags change only on queue events; bus writes never reach them
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_full_flag_r <= 1'b0;
    end else if (rx_push & (rx_cnt_nxt == DEPTH_CNT)) begin
      rx_full_flag_r <= 1'b1;
    end else if (rx_pop & (rx_cnt_nxt != DEPTH_CNT)) begin
      rx_full_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_wait_flag_r <= 1'b0;
    end else if (rx_push) begin
      rx_wait_flag_r <= 1'b1;
    end else if (rx_pop & (rx_cnt_nxt == 9'h000)) begin
      rx_wait_flag_r <= 1'b0;
    end
  end

  // ***********************************************************
  // Control registers and interrupts
  // ***********************************************************
  // Tx space is a level source: its status bit sets again while space remains
  logic [NUM_IRQ-1:0] irq_evt;
  assign irq_evt = {overrun, tx_space, rx_push & (rx_cnt_nxt == DEPTH_CNT), rx_push};

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
      thresh_r <= THRESH_RST;
      irq_mask_r <= IRQ_RST;
    end else if (wr_en) begin
      if (hit_ctrl && lane0) begin
        ctrl_r <= wb_req_i.dat[1:0];
      end
      if (hit_thresh) begin
        if (lane0) begin
          thresh_r[7:0] <= wb_req_i.dat[7:0];
        end
        if (wb_req_i.sel[1]) begin
          thresh_r[8] <= wb_req_i.dat[8];
        end
      end
      if (hit_irq_mask && lane0) begin
        irq_mask_r <= wb_req_i.dat[NUM_IRQ-1:0];
      end
    end
  end

  // Set wins over write-one-to-clear
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IRQ; gi++) begin : g_irq
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          irq_stat_r[gi] <= 1'b0;
        end else if (irq_evt[gi]) begin
          irq_stat_r[gi] <= 1'b1;
        end else if (wr_en && lane0 && hit_irq_stat && wb_req_i.dat[gi]) begin
          irq_stat_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq_o = |(irq_stat_r & irq_mask_r);

  // ***********************************************************
  // Register images
  // ***********************************************************
  // Images are built apart so the read mux stays a plain AND-OR
  logic [31:0] status_img;
  logic [31:0] rx_data_img;
  logic [31:0] ctrl_img;
  logic [31:0] thresh_img;
  logic [31:0] levels_img;
  logic [31:0] irq_stat_img;
  logic [31:0] irq_mask_img;

  // Only flag bits are driven; writes have no path here
  always_comb begin
    status_img = 32'h0000_0000;
    status_img[BIT_TX_SPACE] = tx_space;
    status_img[BIT_RX_FULL] = rx_full_flag_r;
    status_img[BIT_RX_WAIT] = rx_wait_flag_r;
  end

  assign rx_data_img = {24'h00_0000, rx_head_r};

  always_comb begin
    levels_img = 32'h0000_0000;
    levels_img[8:0] = tx_cnt_r;
    levels_img[24:16] = rx_cnt_r;
  end

  always_comb begin
    ctrl_img = 32'h0000_0000;
    ctrl_img[1:0] = ctrl_r;
    thresh_img = 32'h0000_0000;
    thresh_img[8:0] = thresh_r;
    irq_stat_img = 32'h0000_0000;
    irq_stat_img[NUM_IRQ-1:0] = irq_stat_r;
    irq_mask_img = 32'h0000_0000;
    irq_mask_img[NUM_IRQ-1:0] = irq_mask_r;
  end

  // ***********************************************************
  // Read mux and ack
  // ***********************************************************
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0000_0000;
    rd_nxt = rd_nxt | ({32{hit_status}} & status_img);
    rd_nxt = rd_nxt | ({32{hit_rx_data}} & rx_data_img);
    rd_nxt = rd_nxt | ({32{hit_ctrl}} & ctrl_img);
    rd_nxt = rd_nxt | ({32{hit_thresh}} & thresh_img);
    rd_nxt = rd_nxt | ({32{hit_levels}} & levels_img);
    rd_nxt = rd_nxt | ({32{hit_irq_stat}} & irq_stat_img);
    rd_nxt = rd_nxt | ({32{hit_irq_mask}} & irq_mask_img);
  end

  // Ack pulses once; ~ack in access stops a held request being taken twice
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= access;
      if (rd_en) begin
        wb_dat_o <= rd_nxt;
      end
    end
  end
endmodule // ufs_queue_flags

// ### ufs_queue_flags_sva.sv
/* Checker for the queue flag block.
   Sees only the top ports; bound below. */
`timescale 1ns/1ns
module ufs_queue_flags_sva (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire ufs_pkg::ufs_wb_req_t wb_req_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire ufs_pkg::ufs_char_t rx_char_i,
  input wire logic rx_start_i,
  input wire logic tx_pop_i,
  input wire ufs_pkg::ufs_char_t tx_char_o,
  input wire logic irq_o
);
  import ufs_pkg::*;
  // ********
  // Helpers
  // ********
  logic tk;
  logic w_r;
  logic en_r;
  logic [7:0] a_r;
  logic [3:0] msk_r;
  assign tk = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      {w_r, a_r} <= '0;
    end else if (tk) begin
      {w_r, a_r} <= {wb_req_i.we, wb_req_i.adr};
    end
  end
  // Bus decode mirrored; only the enable and mask are needed
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      {en_r, msk_r} <= '0;
    end else if (tk && wb_req_i.we && wb_req_i.sel[0]) begin
      if (wb_req_i.adr == OFF_CTRL) en_r <= wb_req_i.dat[BIT_TX_EN];
      if (wb_req_i.adr == OFF_IRQ_MASK) msk_r <= wb_req_i.dat[3:0];
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // ********
  // Properties
  // ********
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_lat_a: assert property (tk |=> wb_ack_o) else $error("ack late");
  ack_cause_a: assert property (wb_ack_o |-> $past(tk)) else $error("stray ack");
  rst_quiet_a: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o && tx_char_o == '0)
    else $error("outputs not cleared by reset");
  tx_gate_a: assert property (!en_r [*3] |-> !tx_char_o.valid)
    else $error("char shown while tx disabled");
  st_flags_a: assert property (wb_ack_o && !w_r && a_r == OFF_STATUS |->
    !(wb_dat_o[1] && !wb_dat_o[0]) && wb_dat_o[31:3] == '0) else $error("bad status flags");
  unmap_a: assert property (wb_ack_o && !w_r && a_r > 8'h1f |-> wb_dat_o == '0)
    else $error("unmapped read not zero");
  irq_mask_a: assert property (irq_o |-> msk_r != '0 || $past(msk_r) != '0)
    else $error("irq with all masked");
  head_hold_a: assert property (tx_char_o.valid && !tx_pop_i && !$past(tx_pop_i)
    && !wb_req_i.cyc |=> $stable(tx_char_o)) else $error("head moved without pop");
  cover property (tk && wb_req_i.we);
  cover property ($rose(irq_o));
  cover property (tx_pop_i && tx_char_o.valid);
endmodule // ufs_queue_flags_sva
bind ufs_queue_flags ufs_queue_flags_sva i_sva (.*);

// ### ufs_queue_flags_tb_top.sv
/* Bench for the queue flag block.
   Assumes the shifter model and bound checker. */
`timescale 1ns/1ns
`define CHK(n,e,s) begin num_checks++; if ((s) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module ufs_queue_flags_tb_top;
  import ufs_pkg::*;
  logic ref_clk_i = 0;
  logic rst_i = 1;
  logic ack, irq, pop, rxs;
  logic [31:0] dat, q;
  ufs_wb_req_t req = '0;
  ufs_char_t rxc, txc;
  int errors = 0;
  int num_checks = 0;
  int pops;
  // Rows: we, address, write data, expected read
  logic [72:0] rows [8] = '{{1'b0, OFF_STATUS, 32'h0, 32'h4}, {1'b0, OFF_THRESH, 32'h0, 32'h100},
    {1'b0, OFF_CTRL, 32'h0, 32'h0}, {1'b0, OFF_IRQ_MASK, 32'h0, 32'h0},
    {1'b0, OFF_LEVELS, 32'h0, 32'h0}, {1'b0, 8'h20, 32'h0, 32'h0},
    {1'b1, OFF_STATUS, 32'hff, 32'h0}, {1'b0, OFF_STATUS, 32'h0, 32'h4}};
  always #50 ref_clk_i = ~ref_clk_i;
  ufs_queue_flags i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(dat),
    .wb_ack_o(ack), .rx_char_i(rxc), .rx_start_i(rxs), .tx_pop_i(pop), .tx_char_o(txc),
    .irq_o(irq));
  ufs_shifter_model i_far (.ref_clk_i(ref_clk_i), .tx_char_i(txc), .tx_pop_o(pop),
    .rx_char_o(rxc), .rx_start_o(rxs), .pops(pops));
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    req <= '{1'b1, 1'b1, w, 4'hf, a, d};
    @(posedge ref_clk_i);
    for (int t = 0; t < 20 && ack !== 1'b1; t++) @(posedge ref_clk_i);
    if (ack !== 1'b1) errors++;
    q = dat;
    req <= '0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK("reg_read", e, q)
  endtask
  task end_of_test();
    if (errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #2000000;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      bus(rows[i][72], rows[i][71:64], rows[i][63:32]);
      if (!rows[i][72]) `CHK("row", rows[i][31:0], q)
    end
    // ********
    // Transmit side, disabled, then drained
    // ********
    bus(1'b1, OFF_THRESH, 32'h1);
    bus(1'b1, OFF_TX_DATA, 32'h11);
    rd(OFF_STATUS, 32'h4);
    bus(1'b1, OFF_TX_DATA, 32'h22);
    rd(OFF_STATUS, 32'h0);
    bus(1'b1, OFF_THRESH, 32'h100);
    repeat (255) bus(1'b1, OFF_TX_DATA, 32'h33);
    rd(OFF_STATUS, 32'h0);
    rd(OFF_LEVELS, 32'h100);
    `CHK("tx_pops", 0, pops)
    `CHK("tx_valid", 1'b0, txc.valid)
    `CHK("tx_head", 8'h11, txc.data)
    bus(1'b1, OFF_CTRL, 32'h3);
    repeat (600) @(posedge ref_clk_i);
    `CHK("tx_pops", 256, pops)
    rd(OFF_STATUS, 32'h4);
    // ********
    // Receive side and interrupt
    // ********
    bus(1'b1, OFF_IRQ_MASK, 32'h1);
    i_far.send(8'h5a);
    rd(OFF_STATUS, 32'h5);
    `CHK("irq", 1'b1, irq)
    bus(1'b1, OFF_IRQ_MASK, 32'h0);
    `CHK("irq", 1'b0, irq)
    bus(1'b1, OFF_IRQ_STAT, 32'hf);
    rd(OFF_IRQ_STAT, 32'h4);
    rd(OFF_RX_DATA, 32'h5a);
    rd(OFF_STATUS, 32'h4);
    for (int i = 0; i < 256; i++) i_far.send(i[7:0]);
    rd(OFF_STATUS, 32'h7);
    i_far.send(8'hee);
    rd(OFF_RX_DATA, 32'h0);
    rd(OFF_STATUS, 32'h7);
    rd(OFF_RX_DATA, 32'h1);
    rd(OFF_STATUS, 32'h5);
    i_far.send(8'h77);
    i_far.send(8'h88);
    i_far.start_bit();
    rd(OFF_IRQ_STAT, 32'hf);
    rd(OFF_RX_DATA, 32'h2);
    rd(OFF_STATUS, 32'h5);
    rd(OFF_LEVELS, 32'h00ff_0000);
    // Mid-run reset
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(OFF_STATUS, 32'h4);
    rd(OFF_LEVELS, 32'h0);
    end_of_test();
  end
endmodule // ufs_queue_flags_tb_top

// ### ufs_shifter_model.sv
/* Model of the serial shifters beside the block.
   Assumes the bench calls send and start_bit. */
`timescale 1ns/1ns
module ufs_shifter_model (
  input wire logic ref_clk_i,
  input wire ufs_pkg::ufs_char_t tx_char_i,
  output logic tx_pop_o,
  output ufs_pkg::ufs_char_t rx_char_o,
  output logic rx_start_o,
  output int pops
);
  import ufs_pkg::*;
  initial {tx_pop_o, rx_char_o, rx_start_o, pops} = '0;
  // Pops every other cycle; head is registered one edge late
  always @(posedge ref_clk_i) begin
    tx_pop_o <= tx_char_i.valid && !tx_pop_o;
    if (tx_pop_o && tx_char_i.valid) pops <= pops + 1;
  end
  task send(input logic [7:0] d);
    @(posedge ref_clk_i);
    rx_char_o <= '{1'b1, d};
    @(posedge ref_clk_i);
    rx_char_o <= '0;
  endtask
  task start_bit();
    @(posedge ref_clk_i);
    rx_start_o <= 1'b1;
    @(posedge ref_clk_i);
    rx_start_o <= 1'b0;
  endtask
endmodule // ufs_shifter_model
